/* File: core/meas_cfg_ctrl.sv */
// Summary of operation
// - ac+dc voltage configure: defaults, select, stay idle
// - dc current configure: defaults, select, stay idle
// - configure never arms; arm or read does
// - max range for ac+dc voltage is 750 V
// - omitted range is auto, resolution 5.5 digits
// - configure forces immediate trigger, clears calculations
// - autorange steps down below 10 percent
// - autorange steps up above 120 percent
// - manual overrange gives signed overload sentinel
// - query during range change gives sentinel
// - read arms, measures, fills memory and output
// - arm measures into memory only
// - fetch copies memory to output, no trigger
`include "meas_cfg_map.svh"

module meas_cfg_ctrl
   import meas_cfg_pkg::*;
#(
   parameter logic [31:0] FULL_SCALE = `FULL_SCALE_CNT
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire cmd_type cmd_code,
   input wire arg_kind_type range_kind,
   input wire logic [2:0] range_num,
   input wire arg_kind_type res_kind,
   input wire logic res_num_fine,
   input wire logic trig_src_load,
   input wire trig_src_type trig_src_in,
   input wire logic calc_enable_req,
   input wire logic ext_trig_pin,
   input wire logic meas_done,
   input wire logic signed [31:0] meas_value,
   output logic cmd_ready,
   output func_type func_sel,
   output logic range_auto,
   output logic [2:0] range_index,
   output logic ranging,
   output logic res_fine,
   output trig_src_type trig_src,
   output logic calc_active,
   output logic wait_trig,
   output logic meas_start,
   output logic mem_valid,
   output read_kind_type mem_kind,
   output logic [31:0] mem_value,
   output logic out_valid,
   output read_kind_type out_kind,
   output logic [31:0] out_value
);

   localparam logic [31:0] UP_THR = (FULL_SCALE * `UP_PCT) / `PCT_DIV;

   // accepted command strobes
   logic take;
   logic conf_volt, conf_curr, conf_any;
   assign take = cmd_valid && cmd_ready;
   assign conf_volt = take && (cmd_code == cmd_conf_ac_plus_dc || cmd_code == cmd_conf_dc_plus_ac);
   assign conf_curr = take && (cmd_code == cmd_conf_dc_curr);
   assign conf_any = conf_volt || conf_curr;

   // configuration state
   func_type func_r, func_nxt;
   logic fine_r, fine_nxt; // high for 5.5 digits
   trig_src_type trig_r, trig_nxt;
   logic calc_r, calc_nxt;

   // range load toward the tracker
   logic [2:0] max_idx; // top range of the selected function
   logic [2:0] conf_max; // top range of the function being configured
   logic ld_auto;
   logic [2:0] ld_idx;
   logic step_up;

   assign max_idx = (func_r == func_dc_curr) ? `RANGE_CURR_MAX_IDX : `RANGE_VOLT_MAX_IDX;
   assign conf_max = conf_curr ? `RANGE_CURR_MAX_IDX : `RANGE_VOLT_MAX_IDX;

   // decode the optional range argument
   always_comb
   begin
      ld_auto = 1'b0;
      ld_idx = `RANGE_MIN_IDX;
      case (range_kind)
         arg_omitted, arg_auto, arg_def: ld_auto = 1'b1;
         arg_max: ld_idx = conf_max;
         arg_min: ld_idx = `RANGE_MIN_IDX;
         // numeric values past the top clamp to the top range
         arg_numeric: ld_idx = (range_num > conf_max) ? conf_max : range_num;
         default: ld_auto = 1'b1;
      endcase
   end

   // next configuration
   always_comb
   begin
      func_nxt = func_r;
      fine_nxt = fine_r;
      trig_nxt = trig_r;
      calc_nxt = calc_r;
      if (trig_src_load)
         trig_nxt = trig_src_in;
      if (calc_enable_req)
         calc_nxt = 1'b1;
      if (conf_any)
      begin
         // defaults first, then the function and its arguments
         func_nxt = conf_curr ? func_dc_curr : func_ac_plus_dc_volt;
         trig_nxt = trig_immediate;
         calc_nxt = 1'b0;
         case (res_kind)
            arg_max: fine_nxt = 1'b0;
            arg_numeric: fine_nxt = res_num_fine;
            default: fine_nxt = 1'b1;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         func_r <= func_ac_plus_dc_volt;
         fine_r <= `RST_FINE;
         trig_r <= trig_immediate;
         calc_r <= 1'b0;
      end
      else
      begin
         func_r <= func_nxt;
         fine_r <= fine_nxt;
         trig_r <= trig_nxt;
         calc_r <= calc_nxt;
      end
   end

   // acquisition state, declared here because the tracker watches it
   ctrl_state_type st_r, st_nxt;

   // autorange and settle tracking
   range_tracker #(
      .FULL_SCALE(FULL_SCALE)
   ) u_range (
      .ref_clk(ref_clk),
      .rst(rst),
      .load(conf_any),
      .load_auto(ld_auto),
      .load_index(ld_idx),
      .max_index(max_idx),
      .sample_valid(meas_done && st_r == st_measure),
      .sample_value(meas_value),
      .step_up(step_up),
      .auto_en(range_auto),
      .index(range_index),
      .ranging(ranging)
   );

   // external trigger pin: two stages, then edge detect on the second
   logic ext_s1_r, ext_s2_r, ext_prev_r, ext_rise;
   assign ext_rise = ext_s2_r && !ext_prev_r;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_prev_r <= 1'b0;
      end
      else
      begin
         ext_s1_r <= ext_trig_pin;
         ext_s2_r <= ext_s1_r;
         ext_prev_r <= ext_s2_r;
      end
   end

   // acquisition sequence and reading stores
   logic is_read_r, is_read_nxt; // pending acquisition answers the host
   logic mv_r, mv_nxt;
   read_kind_type mk_r, mk_nxt;
   logic [31:0] mval_r, mval_nxt;
   logic ov_r, ov_nxt;
   read_kind_type ok_r, ok_nxt;
   logic [31:0] oval_r, oval_nxt;
   logic fire, over;
   read_kind_type rk; // kind of the reading just finished

   assign fire = (st_r == st_wait_trig) && (trig_r == trig_immediate || ext_rise);
   assign over = magnitude(meas_value) > UP_THR;

   // classify a finished reading
   always_comb
   begin
      rk = read_normal;
      if (ranging || step_up)
         rk = read_range_change;
      else if (over)
         rk = meas_value[31] ? read_ovl_neg : read_ovl_pos;
   end

   always_comb
   begin
      st_nxt = st_r;
      is_read_nxt = is_read_r;
      mv_nxt = mv_r;
      mk_nxt = mk_r;
      mval_nxt = mval_r;
      ov_nxt = 1'b0;
      ok_nxt = ok_r;
      oval_nxt = oval_r;
      case (st_r)
         st_idle:
         begin
            // configure commands leave the sequence idle
            if (take && (cmd_code == cmd_arm || cmd_code == cmd_read))
            begin
               st_nxt = st_wait_trig;
               is_read_nxt = (cmd_code == cmd_read);
            end
            else if (take && cmd_code == cmd_fetch)
            begin
               // nothing is triggered; the stored value is copied out, or the range-change sentinel while ranging
               ov_nxt = 1'b1;
               ok_nxt = ranging ? read_range_change : mk_r;
               oval_nxt = ranging ? 32'h0 : mval_r;
            end
         end
         st_wait_trig:
            if (fire)
               st_nxt = st_measure;
         st_measure:
            if (meas_done)
            begin
               st_nxt = st_idle;
               mv_nxt = 1'b1;
               mk_nxt = rk;
               mval_nxt = (rk == read_normal) ? meas_value : 32'h0;
               if (is_read_r)
               begin
                  ov_nxt = 1'b1;
                  ok_nxt = rk;
                  oval_nxt = (rk == read_normal) ? meas_value : 32'h0;
               end
            end
         default: st_nxt = st_idle;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st_r <= st_idle;
         is_read_r <= 1'b0;
         mv_r <= 1'b0;
         mk_r <= read_normal;
         mval_r <= 32'h0;
         ov_r <= 1'b0;
         ok_r <= read_normal;
         oval_r <= 32'h0;
      end
      else
      begin
         st_r <= st_nxt;
         is_read_r <= is_read_nxt;
         mv_r <= mv_nxt;
         mk_r <= mk_nxt;
         mval_r <= mval_nxt;
         ov_r <= ov_nxt;
         ok_r <= ok_nxt;
         oval_r <= oval_nxt;
      end
   end

   // outputs
   assign cmd_ready = (st_r == st_idle);
   assign func_sel = func_r;
   assign res_fine = fine_r;
   assign trig_src = trig_r;
   assign calc_active = calc_r;
   assign wait_trig = (st_r == st_wait_trig);
   assign meas_start = fire;
   assign mem_valid = mv_r;
   assign mem_kind = mk_r;
   assign mem_value = mval_r;
   assign out_valid = ov_r;
   assign out_kind = ok_r;
   assign out_value = oval_r;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_conf_done;
      (st_r == st_idle) && (trig_r == trig_immediate) && !calc_r;
   endsequence

   property p_conf_volt;
      conf_volt |=> s_conf_done and (func_r == func_ac_plus_dc_volt);
   endproperty
   a_conf_volt: assert property (p_conf_volt) else $error("voltage configure wrong");

   property p_conf_curr;
      conf_curr |=> s_conf_done and (func_r == func_dc_curr);
   endproperty
   a_conf_curr: assert property (p_conf_curr) else $error("current configure wrong");

   // one cycle only: an arm may legally follow a configure back to back
   property p_conf_no_arm;
      conf_any |=> !wait_trig && !meas_start;
   endproperty
   a_conf_no_arm: assert property (p_conf_no_arm) else $error("configure armed");

   property p_max_volt;
      (conf_volt && range_kind == arg_max) |=> !range_auto && (range_index == 3'h4);
   endproperty
   a_max_volt: assert property (p_max_volt) else $error("max range not 750 V");

   property p_defaults;
      (conf_any && range_kind == arg_omitted && res_kind == arg_omitted) |=> range_auto && fine_r;
   endproperty
   a_defaults: assert property (p_defaults) else $error("omitted arguments not defaulted");

   property p_def_kw;
      (conf_any && range_kind == arg_def && res_kind == arg_def) |=> range_auto && fine_r;
   endproperty
   a_def_kw: assert property (p_def_kw) else $error("def keyword not defaulted");

   property p_trig_clear;
      (calc_r && conf_any) |=> !calc_r && (trig_r == trig_immediate);
   endproperty
   a_trig_clear: assert property (p_trig_clear) else $error("configure left calc or trigger");

   property p_ovl;
      (st_r == st_measure && meas_done && !range_auto && over && !ranging)
         |=> (mem_kind == ($past(meas_value[31]) ? read_ovl_neg : read_ovl_pos));
   endproperty
   a_ovl: assert property (p_ovl) else $error("overload sentinel missing");

   property p_rc;
      (take && cmd_code == cmd_fetch && ranging) |=> out_valid && (out_kind == read_range_change);
   endproperty
   a_rc: assert property (p_rc) else $error("range change sentinel missing");

   sequence s_read_go;
      take && cmd_code == cmd_read && trig_r == trig_immediate;
   endsequence

   property p_read;
      s_read_go |=> wait_trig && meas_start ##1 (st_r == st_measure);
   endproperty
   a_read: assert property (p_read) else $error("read did not trigger");

   property p_arm_mem;
      (st_r == st_measure && meas_done && !is_read_r) |=> mem_valid && !out_valid;
   endproperty
   a_arm_mem: assert property (p_arm_mem) else $error("arm touched output");

   property p_fetch;
      (take && cmd_code == cmd_fetch && !ranging) |=> out_valid && (out_value == mem_value) && !meas_start;
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch wrong");

endmodule

/* File: core/meas_cfg_map.svh */
`ifndef MEAS_CFG_MAP_SVH
`define MEAS_CFG_MAP_SVH

// range indices: 0 is the smallest range of either function
`define RANGE_MIN_IDX 3'h0
// 750 V rms range, the largest voltage range
`define RANGE_VOLT_MAX_IDX 3'h4
// 3 A range, the largest current range
`define RANGE_CURR_MAX_IDX 3'h3

// reading counts at the full scale of any range
`define FULL_SCALE_CNT 32'h000186A0
// autorange thresholds in percent of full scale
`define DOWN_PCT 32'h0000000A
`define UP_PCT 32'h00000078
`define PCT_DIV 32'h00000064

// clock period and least settling time of a range change
`define CLK_PERIOD_NS 32'h00000028
`define RANGE_SETTLE_NS 32'h00000FA0
`define RANGE_SETTLE_CYC ((`RANGE_SETTLE_NS + `CLK_PERIOD_NS - 32'h1) / `CLK_PERIOD_NS)

// reset values of the configuration
`define RST_AUTO 1'h1
`define RST_FINE 1'h1

`endif

/* File: core/meas_cfg_pkg.sv */
package meas_cfg_pkg;

   // decoded host command
   typedef enum logic [2:0] {
      cmd_none = 3'b000,
      cmd_conf_ac_plus_dc = 3'b001,
      cmd_conf_dc_plus_ac = 3'b010,
      cmd_conf_dc_curr = 3'b011,
      cmd_arm = 3'b100,
      cmd_read = 3'b101,
      cmd_fetch = 3'b110
   } cmd_type;

   // kind of a range or resolution argument
   typedef enum logic [2:0] {
      arg_omitted = 3'b000,
      arg_numeric = 3'b001,
      arg_auto = 3'b010,
      arg_max = 3'b011,
      arg_min = 3'b100,
      arg_def = 3'b101
   } arg_kind_type;

   // selected measurement function
   typedef enum logic {
      func_ac_plus_dc_volt = 1'b0,
      func_dc_curr = 1'b1
   } func_type;

   typedef enum logic {
      trig_immediate = 1'b0,
      trig_external = 1'b1
   } trig_src_type;

   // what a stored or returned reading holds
   typedef enum logic [1:0] {
      read_normal = 2'b00,
      read_ovl_pos = 2'b01,
      read_ovl_neg = 2'b10,
      read_range_change = 2'b11
   } read_kind_type;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_wait_trig = 2'b01,
      st_measure = 2'b10
   } ctrl_state_type;

   // magnitude of a signed reading, saturating at the top
   function automatic logic [31:0] magnitude(input logic signed [31:0] v);
      logic [31:0] m;
      m = v[31] ? 32'(-v) : 32'(v);
      if (m[31])
         m = 32'h7FFFFFFF;
      return m;
   endfunction

endpackage

/* File: core/range_tracker.sv */
`include "meas_cfg_map.svh"

module range_tracker
   import meas_cfg_pkg::*;
#(
   parameter logic [31:0] FULL_SCALE = `FULL_SCALE_CNT,
   parameter logic [15:0] SETTLE_CYC = 16'(`RANGE_SETTLE_CYC)
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic load_auto,
   input wire logic [2:0] load_index,
   input wire logic [2:0] max_index,
   input wire logic sample_valid,
   input wire logic signed [31:0] sample_value,
   output logic step_up,
   output logic auto_en,
   output logic [2:0] index,
   output logic ranging
);

   // thresholds as reading counts
   localparam logic [31:0] DOWN_THR = (FULL_SCALE * `DOWN_PCT) / `PCT_DIV;
   localparam logic [31:0] UP_THR = (FULL_SCALE * `UP_PCT) / `PCT_DIV;

   logic auto_r, auto_nxt;
   logic [2:0] idx_r, idx_nxt;
   logic [15:0] cnt_r, cnt_nxt; // settle countdown
   logic step_down;
   logic [31:0] mag;

   assign mag = magnitude(sample_value);
   // no new step while the previous one is still settling
   assign step_up = sample_valid && auto_r && (cnt_r == 16'h0) && (mag > UP_THR) && (idx_r < max_index);
   assign step_down = sample_valid && auto_r && (cnt_r == 16'h0) && (mag < DOWN_THR) && (idx_r != 3'h0);
   assign auto_en = auto_r;
   assign index = idx_r;
   assign ranging = (cnt_r != 16'h0);

   // next range and settle state
   always_comb
   begin
      auto_nxt = auto_r;
      idx_nxt = idx_r;
      cnt_nxt = cnt_r;
      if (load)
      begin
         // a new configuration cancels any pending step
         auto_nxt = load_auto;
         idx_nxt = load_index;
         cnt_nxt = 16'h0;
      end
      else if (step_up)
      begin
         idx_nxt = idx_r + 3'h1;
         cnt_nxt = SETTLE_CYC;
      end
      else if (step_down)
      begin
         idx_nxt = idx_r - 3'h1;
         cnt_nxt = SETTLE_CYC;
      end
      else if (cnt_r != 16'h0)
         cnt_nxt = cnt_r - 16'h1;
   end

   // registers only
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         auto_r <= `RST_AUTO;
         idx_r <= `RANGE_MIN_IDX;
         cnt_r <= 16'h0;
      end
      else
      begin
         auto_r <= auto_nxt;
         idx_r <= idx_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_step_down;
      (step_down && !load) |=> (idx_r == $past(idx_r) - 3'h1) && ranging;
   endproperty
   a_step_down: assert property (p_step_down) else $error("autorange did not step down");

   property p_step_up;
      (sample_valid && auto_r && !ranging && !load && mag > UP_THR && idx_r < max_index)
         |=> (idx_r == $past(idx_r) + 3'h1) && (cnt_r == SETTLE_CYC);
   endproperty
   a_step_up: assert property (p_step_up) else $error("autorange did not step up");

endmodule

/* File: verif/analog_path_model.sv */
// behavioural stand-in for the analog measurement path
module analog_path_model
(
   input wire logic ref_clk,
   input wire logic meas_start,
   input wire logic [7:0] delay_cyc,
   input wire logic signed [31:0] value_in,
   output logic meas_done,
   output logic signed [31:0] meas_value
);
   timeunit 1ns;
   timeprecision 1ps;

   // quiet outputs from time zero, then answer each trigger after a chosen delay
   // value is inverted outside the done cycle so a stale read cannot pass
   // one process only, so each output has a single driver
   initial
   begin
      meas_done = 1'b0;
      meas_value = 32'h00000000;
      forever
      begin
         @(negedge ref_clk iff meas_start === 1'b1);
         repeat (delay_cyc) @(negedge ref_clk);
         meas_done = 1'b1;
         meas_value = value_in;
         @(negedge ref_clk);
         meas_done = 1'b0;
         meas_value = ~value_in;
      end
   end
endmodule

/* File: verif/meas_cfg_ctrl_tb.sv */
module meas_cfg_ctrl_tb
   import meas_cfg_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   logic ref_clk = 1'b0; // 25 MHz
   logic rst = 1'b1;
   logic cmd_valid = 1'b0;
   cmd_type cmd_code = cmd_none;
   arg_kind_type range_kind = arg_omitted;
   logic [2:0] range_num = 3'h0;
   arg_kind_type res_kind = arg_omitted;
   logic res_num_fine = 1'b1;
   logic trig_src_load = 1'b0;
   trig_src_type trig_src_in = trig_immediate;
   logic calc_enable_req = 1'b0;
   logic ext_trig_pin = 1'b0;
   logic meas_done;
   logic signed [31:0] meas_value;
   logic [7:0] delay_cyc = 8'h01; // partner answer delay
   logic signed [31:0] value_in = 32'h00000000; // partner next reading
   logic cmd_ready, range_auto, ranging, res_fine, calc_active, wait_trig, meas_start;
   logic mem_valid, out_valid;
   func_type func_sel;
   trig_src_type trig_src;
   logic [2:0] range_index;
   read_kind_type mem_kind, out_kind;
   logic [31:0] mem_value, out_value;
   int fail_count = 0;
   int checked = 0;
   int cycles = 0;

   meas_cfg_ctrl dut (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .range_kind(range_kind), .range_num(range_num), .res_kind(res_kind), .res_num_fine(res_num_fine),
      .trig_src_load(trig_src_load), .trig_src_in(trig_src_in), .calc_enable_req(calc_enable_req),
      .ext_trig_pin(ext_trig_pin), .meas_done(meas_done), .meas_value(meas_value), .cmd_ready(cmd_ready),
      .func_sel(func_sel), .range_auto(range_auto), .range_index(range_index), .ranging(ranging),
      .res_fine(res_fine), .trig_src(trig_src), .calc_active(calc_active), .wait_trig(wait_trig),
      .meas_start(meas_start), .mem_valid(mem_valid), .mem_kind(mem_kind), .mem_value(mem_value),
      .out_valid(out_valid), .out_kind(out_kind), .out_value(out_value));

   analog_path_model partner (.ref_clk(ref_clk), .meas_start(meas_start), .delay_cyc(delay_cyc),
      .value_in(value_in), .meas_done(meas_done), .meas_value(meas_value));

   always #20 ref_clk = ~ref_clk;

   // hang guard, well above the few hundred cycles the tests need
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         fail_count++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         $display("ERROR %s expected %h seen %h", what, exp, seen);
         fail_count++;
      end
   endtask

   // offer a command at a falling edge, hold it until taken; returns one cycle after
   task automatic send(input cmd_type c, input arg_kind_type rk, input logic [2:0] rn,
                       input arg_kind_type sk, input logic fine);
      int n;
      n = 0;
      @(negedge ref_clk);
      cmd_valid = 1'b1;
      cmd_code = c;
      range_kind = rk;
      range_num = rn;
      res_kind = sk;
      res_num_fine = fine;
      // ready only moves on rising edges, so its mid-cycle level predicts the take
      while (cmd_ready !== 1'b1 && n < 200)
      begin
         n++;
         @(negedge ref_clk);
      end
      @(negedge ref_clk);
      cmd_valid = 1'b0;
   endtask

   // arm or read with a chosen reading; reports whether the output buffer was loaded
   task automatic measure(input cmd_type c, input logic signed [31:0] v, input logic [7:0] d,
                          input logic ext, output logic saw);
      int n;
      n = 0;
      saw = 1'b0;
      value_in = v;
      delay_cyc = d;
      send(c, arg_omitted, 3'h0, arg_omitted, 1'b1);
      check("wait_trig", wait_trig, 1'b1);
      check("trigger", meas_start, !ext);
      if (ext)
      begin
         repeat (5) @(negedge ref_clk);
         check("still waiting", wait_trig, 1'b1);
         ext_trig_pin = 1'b1;
      end
      while (cmd_ready !== 1'b1 && n < 100)
      begin
         n++;
         @(negedge ref_clk);
         saw = saw | (out_valid === 1'b1);
      end
      ext_trig_pin = 1'b0;
   endtask

   // preload a stale trigger source and calculation, then configure and judge every setting
   task automatic conf_case(input cmd_type c, input arg_kind_type rk, input logic [2:0] rn,
                            input arg_kind_type sk, input logic fine, input func_type f,
                            input logic au, input logic [2:0] idx, input logic rf);
      @(negedge ref_clk);
      trig_src_load = 1'b1;
      trig_src_in = trig_external;
      calc_enable_req = 1'b1;
      @(negedge ref_clk);
      trig_src_load = 1'b0;
      calc_enable_req = 1'b0;
      check("trig loaded", trig_src, trig_external);
      check("calc on", calc_active, 1'b1);
      send(c, rk, rn, sk, fine);
      check("func", func_sel, f);
      check("auto", range_auto, au);
      check("index", range_index, idx);
      check("res", res_fine, rf);
      check("trig", trig_src, trig_immediate);
      check("calc", calc_active, 1'b0);
      check("idle", wait_trig, 1'b0);
      check("no start", meas_start, 1'b0);
   endtask

   task automatic t_reset();
      check("rst ready", cmd_ready, 1'b1);
      check("rst auto", range_auto, 1'b1);
      check("rst res", res_fine, 1'b1);
      check("rst out", out_valid, 1'b0);
      check("rst mem", mem_valid, 1'b0);
   endtask

   task automatic t_conf();
      conf_case(cmd_conf_dc_curr, arg_omitted, 3'h2, arg_omitted, 1'b0, func_dc_curr, 1'b1, 3'h0, 1'b1);
      conf_case(cmd_conf_ac_plus_dc, arg_max, 3'h0, arg_max, 1'b1, func_ac_plus_dc_volt, 1'b0, 3'h4, 1'b0);
      conf_case(cmd_conf_dc_curr, arg_max, 3'h0, arg_min, 1'b0, func_dc_curr, 1'b0, 3'h3, 1'b1);
      conf_case(cmd_conf_dc_plus_ac, arg_def, 3'h3, arg_def, 1'b0, func_ac_plus_dc_volt, 1'b1, 3'h0, 1'b1);
      conf_case(cmd_conf_ac_plus_dc, arg_numeric, 3'h2, arg_numeric, 1'b0, func_ac_plus_dc_volt, 1'b0, 3'h2,
                1'b0);
   endtask

   // manual range for speed, then readings at and past the overload boundary
   task automatic t_overload();
      logic saw;
      conf_case(cmd_conf_dc_curr, arg_numeric, 3'h1, arg_auto, 1'b0, func_dc_curr, 1'b0, 3'h1, 1'b1);
      measure(cmd_read, 32'sd120000, 8'h14, 1'b0, saw);
      check("read out", saw, 1'b1);
      check("read mem", mem_valid, 1'b1);
      check("edge kind", out_kind, read_normal);
      check("edge val", out_value, 32'h0001D4C0);
      measure(cmd_read, 32'sd120001, 8'h01, 1'b0, saw);
      check("pos kind", out_kind, read_ovl_pos);
      check("pos mem", mem_kind, read_ovl_pos);
      measure(cmd_read, -32'sd120001, 8'h01, 1'b0, saw);
      check("neg kind", out_kind, read_ovl_neg);
      check("neg val", out_value, 32'h00000000);
   endtask

   // arm fills memory only; fetch moves it out without a new trigger
   task automatic t_arm_fetch();
      logic saw;
      measure(cmd_arm, 32'sd7000, 8'h14, 1'b0, saw);
      check("arm out", saw, 1'b0);
      check("arm mem", mem_value, 32'h00001B58);
      check("arm memk", mem_kind, read_normal);
      check("arm keep", out_kind, read_ovl_neg);
      repeat (2)
      begin
         send(cmd_fetch, arg_omitted, 3'h0, arg_omitted, 1'b1);
         check("fetch valid", out_valid, 1'b1);
         check("fetch start", meas_start, 1'b0);
         check("fetch val", out_value, 32'h00001B58);
      end
   endtask

   task automatic t_autorange();
      logic saw;
      int n;
      n = 0;
      conf_case(cmd_conf_ac_plus_dc, arg_auto, 3'h0, arg_omitted, 1'b0, func_ac_plus_dc_volt, 1'b1, 3'h0,
                1'b1);
      measure(cmd_read, 32'sd130000, 8'h01, 1'b0, saw);
      check("up kind", out_kind, read_range_change);
      check("up index", range_index, 3'h1);
      check("ranging", ranging, 1'b1);
      send(cmd_fetch, arg_omitted, 3'h0, arg_omitted, 1'b1);
      check("fetch rc", out_kind, read_range_change);
      // host holds off until the range has settled
      while (ranging === 1'b1 && n < 150)
      begin
         n++;
         @(negedge ref_clk);
      end
      check("settled", ranging, 1'b0);
      measure(cmd_read, 32'sd5000, 8'h01, 1'b0, saw);
      check("low kind", out_kind, read_normal);
      check("down index", range_index, 3'h0);
   endtask

   // external source holds the trigger until the pin rises
   task automatic t_ext();
      logic saw;
      // fixed smallest range, which also cancels the settle left by the last step down
      conf_case(cmd_conf_ac_plus_dc, arg_min, 3'h0, arg_omitted, 1'b1, func_ac_plus_dc_volt, 1'b0, 3'h0,
                1'b1);
      @(negedge ref_clk);
      trig_src_load = 1'b1;
      trig_src_in = trig_external;
      @(negedge ref_clk);
      trig_src_load = 1'b0;
      measure(cmd_read, 32'sd9000, 8'h01, 1'b1, saw);
      check("ext out", saw, 1'b1);
      check("ext val", out_value, 32'h00002328);
   endtask

   initial
   begin
      repeat (10) @(negedge ref_clk);
      t_reset();
      rst = 1'b0;
      t_reset();
      t_conf();
      t_overload();
      t_arm_fetch();
      t_autorange();
      t_ext();
      tally_and_finish();
   end
endmodule
